/* File: verilog/vdm_regs.svh */
// Constants for the voice-plus-data mode and rate selector
`ifndef VDM_REGS_SVH
`define VDM_REGS_SVH
// Command opcodes
`define VDM_OP_MODE      3'h0
`define VDM_OP_MODSEL    3'h1
`define VDM_OP_BURST     3'h2
`define VDM_OP_LINESEL   3'h3
`define VDM_OP_CLASS     3'h4
`define VDM_OP_CID       3'h5
`define VDM_OP_INQUIRY   3'h6
// Operating modes
`define VDM_MODE_DATA    2'h0
`define VDM_MODE_DIGITAL 2'h1
`define VDM_MODE_ANALOG  2'h2
`define VDM_MODE_AUTO    2'h3
// Modulations
`define VDM_MOD_V61      2'h0
`define VDM_MOD_MID      2'h1
`define VDM_MOD_HIGH     2'h2
// Rate indices: 4800 plus 2400 per step
`define VDM_R4800        4'h0
`define VDM_R7200        4'h1
`define VDM_R9600        4'h2
`define VDM_R12000       4'h3
`define VDM_R14400       4'h4
`define VDM_R28800       4'ha
`define VDM_HIGH_STEPS   4'h6
`define VDM_MID_STEPS    4'h2
// Symbol rate, line selects, service classes
`define VDM_SYM_AUTO     3'h0
`define VDM_LS_HANDSET   4'h0
`define VDM_LS_HEADSET   4'h5
`define VDM_LS_SPKR      4'h6
`define VDM_LS_MAX       4'h9
`define VDM_CLS_VOICE    8'h08
`define VDM_CLS_TDM      8'h50
// Reset values
`define VDM_RST_BURST    1'b1
`define VDM_RST_AUTOMOD  1'b1
`define VDM_ON           1'b1
`define VDM_OFF          1'b0
`endif

/* File: verilog/vdm_pkg.sv */
// Types for the voice-plus-data mode and rate selector
package vdm_pkg;
  typedef logic [3:0] vdm_rate_t;
  typedef logic [1:0] vdm_mod_t;
  typedef enum logic [2:0] {VDM_IDLE, VDM_NEGOT, VDM_VOICE_DATA, VDM_DATA_ONLY} vdm_state_e;
  typedef struct packed {
    logic [2:0] opcode;
    logic [7:0] arg0;
    logic       has_min;
    vdm_rate_t  min_rate;
    logic       has_max;
    vdm_rate_t  max_rate;
    logic [2:0] symbol_rate;
  } vdm_cmd_s;
  typedef struct packed {
    logic       connect_req;
    logic       hangup;
    logic       remote_voice_data;
    logic [2:0] remote_mods;
    vdm_rate_t  line_rate;
    logic       handset_onhook;
    logic       audio_energy;
  } vdm_link_s;
  typedef struct packed {
    logic       voice_data_active;
    logic       digital_active;
    vdm_mod_t   active_mod;
    vdm_rate_t  speed;
    logic       audio_open;
    logic       upshifted;
  } vdm_stat_s;
endpackage

/* File: verilog/vdm_select.sv */
// Voice-plus-data mode and rate selector: command decode and link control
//
// How it works
// - Voice-data only when remote also configured
// - Mode 0 data, 1 digital, 2 analog, 3 auto
// - Speed limits accepted only where modulation supports
// - Symbol rate 0 automatic, 1-7 reserved
// - Modulation 0 V.61, 1 mid, 2 high
// - Unsupported fixed modulation errors, selection kept
// - Fixed modulation unsupported remotely disconnects call
// - Automatic fallback high, mid, V.61, data
// - High rate audio six steps below line
// - High rate upshifts when handset on-hook
// - Mid rate audio at least two steps below
// - Mid rate upshifts when burst on and no audio detected
// - V.61 runs 4800 always
// - Burst default on, mid rate channel open on energy
// - Silence in burst mode shifts mid rate speed up
// - Burst off keeps audio channel always open
// - Audio path handset, headset or speakerphone
// - Speakerphone only class 8, line select 6
// - Speakerphone enables acoustic and line echo cancel
// - Class 80 enables time-multiplexed voice/data
// - Caller ident passes data, answers inquiry
`timescale 1ns/100ps
`include "vdm_regs.svh"

module vdm_select #(
  parameter bit HIGH_MODEL = 1'b1
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                cmd_valid,
  input  wire vdm_pkg::vdm_cmd_s   cmd,
  output logic                     rsp_ok,
  output logic                     rsp_err,
  output logic [7:0]               rsp_data,
  input  wire vdm_pkg::vdm_link_s  link,
  output vdm_pkg::vdm_stat_s       stat,
  output logic                     disconnect,
  output logic [3:0]               audio_route,
  output logic                     speakerphone_active,
  output logic                     echo_cancel_en,
  output logic                     tdm_voice_data_en,
  output logic                     caller_ident_pass
);
  import vdm_pkg::*;

  // ==========================================================
  // Behaviour notes
  // Commands are taken on any enabled cycle with the strobe high
  // Every taken command gets exactly one answer pulse, ok or error
  // A refused command leaves every stored setting as it was
  // Speed values are rate indices, one index per 2400 step
  // Index zero is the slowest rate, so clamps work on plain compares
  // The modulation command carries the automatic fallback flag in bit 2
  // That command also resets the speed window to the full range
  // Of the newly chosen modulation, so old limits cannot block it
  // A mode command without limits takes the full range of the
  // Currently stored modulation
  // Negotiation tries one modulation per enabled cycle
  // Fallback steps down by one code: high, mid, then the slow one
  // After the slow modulation the call stays up as data only
  // With fallback off a refused modulation drops the call at once
  // Digital mode skips the modulation trial, the remote decides
  // Status follows the call state one cycle late
  // Speed shown outside a voice-data call is the data-only speed
  // Upshift in high-rate mode follows the handset hook switch
  // Upshift in mid-rate mode needs burst gating and a quiet line
  // With burst gating off the audio channel never closes
  // Path controls follow the stored selects one cycle late
  // Speakerphone and echo cancelling share one decode
  // So they can never disagree
  // The inquiry answer holds until the next inquiry
  // Hazard: the remote capability bits are sampled every cycle
  // A change during negotiation can move the fallback point
  // Hazard: hangup wins over acceptance in the same cycle
  // Limitation: the symbol rate is stored but only auto is legal
  // Limitation: caller ident data itself passes outside this block
  // Clock enable low freezes settings, answers and the call state
  // Reset is synchronous and is obeyed whatever the enable does

  // ==========================================================
  // Configuration held from commands
  logic [1:0]  mode;
  vdm_mod_t    mod_sel;
  logic        automod;
  logic        burst_en;
  vdm_rate_t   min_rate;
  vdm_rate_t   max_rate;
  logic [2:0]  symbol_rate;
  logic [3:0]  voice_line_select;
  logic [7:0]  service_class_select;
  logic        caller_ident_enable;

  // ==========================================================
  // Link control state
  vdm_state_e  state;
  vdm_mod_t    cur_mod;

  // Default modulation depends on model
  wire vdm_mod_t def_mod = HIGH_MODEL ? `VDM_MOD_HIGH : `VDM_MOD_MID;

  // Highest speed with audio that each modulation supports
  function automatic vdm_rate_t top_rate(input vdm_mod_t m);
    case (m)
      `VDM_MOD_V61: top_rate = `VDM_R4800;
      `VDM_MOD_MID: top_rate = `VDM_R9600;
      default:      top_rate = `VDM_R14400;
    endcase
  endfunction

  // ==========================================================
  // Command decode
  wire vdm_mod_t  req_mod     = cmd.arg0[1:0];
  wire vdm_rate_t cmd_min     = cmd.has_min ? cmd.min_rate : `VDM_R4800;
  wire vdm_rate_t cmd_max     = cmd.has_max ? cmd.max_rate : top_rate(mod_sel);
  wire            arg_hi_zero = (cmd.arg0[7:2] == 6'h00);
  wire            mode_ok     = arg_hi_zero
                              & (cmd_max <= top_rate(mod_sel))
                              & (cmd_min <= cmd_max)
                              & (cmd.symbol_rate == `VDM_SYM_AUTO);
  wire            mod_hi_zero = (cmd.arg0[7:3] == 5'h00); // Bit 2 is the fallback flag
  wire            mod_ok      = mod_hi_zero & (cmd.arg0[1:0] <= `VDM_MOD_HIGH)
                              & ((req_mod != `VDM_MOD_HIGH) | HIGH_MODEL);
  wire            bit_ok      = (cmd.arg0[7:1] == 7'h00);
  wire            ls_ok       = (cmd.arg0 <= {4'h0, `VDM_LS_MAX});
  logic           cmd_good;
  always_comb begin
    case (cmd.opcode)
      `VDM_OP_MODE:    cmd_good = mode_ok;
      `VDM_OP_MODSEL:  cmd_good = mod_ok;
      `VDM_OP_BURST:   cmd_good = bit_ok;
      `VDM_OP_LINESEL: cmd_good = ls_ok;
      `VDM_OP_CLASS:   cmd_good = 1'b1;
      `VDM_OP_CID:     cmd_good = bit_ok;
      `VDM_OP_INQUIRY: cmd_good = 1'b1;
      default:         cmd_good = 1'b0;
    endcase
  end
  wire do_cmd = ce & cmd_valid & cmd_good;

  // ==========================================================
  // Rate arithmetic for the modulation under trial
  wire vdm_rate_t line_high = (link.line_rate > `VDM_R28800) ? `VDM_R28800 : link.line_rate;
  wire vdm_rate_t line_mid  = (link.line_rate > `VDM_R14400) ? `VDM_R14400 : link.line_rate;
  wire vdm_rate_t cap_high  = (line_high > `VDM_HIGH_STEPS) ? line_high - `VDM_HIGH_STEPS
                                                            : `VDM_R4800;
  wire vdm_rate_t cap_mid0  = (line_mid > `VDM_MID_STEPS) ? line_mid - `VDM_MID_STEPS
                                                          : `VDM_R4800;
  wire vdm_rate_t cap_mid   = (cap_mid0 > `VDM_R9600) ? `VDM_R9600 : cap_mid0;
  vdm_rate_t cap_rate;
  vdm_rate_t data_rate;
  always_comb begin
    case (cur_mod)
      `VDM_MOD_HIGH: begin
        cap_rate  = cap_high;
        data_rate = line_high;
      end
      `VDM_MOD_MID: begin
        cap_rate  = cap_mid;
        data_rate = line_mid;
      end
      default: begin
        cap_rate  = `VDM_R4800;
        data_rate = `VDM_R4800;
      end
    endcase
  end
  wire            remote_has = link.remote_mods[cur_mod];
  wire            fits_min   = (cap_rate >= min_rate);
  wire vdm_rate_t audio_rate = (cap_rate > max_rate) ? max_rate : cap_rate;
  wire            wants_vd   = (mode != `VDM_MODE_DATA) & link.remote_voice_data;
  wire            is_digital = (mode == `VDM_MODE_DIGITAL);

  // ==========================================================
  // Audio presence and speed in an established voice-data call
  wire burst_gate  = burst_en & (cur_mod == `VDM_MOD_MID);
  wire chan_open   = burst_gate ? link.audio_energy : 1'b1;
  wire high_up     = (cur_mod == `VDM_MOD_HIGH) & link.handset_onhook;
  wire mid_up      = burst_gate & ~link.audio_energy;
  wire go_up       = high_up | mid_up;
  wire vdm_rate_t vd_speed = go_up ? data_rate : audio_rate;

  // ==========================================================
  // Derived path controls
  wire spk_on = (service_class_select == `VDM_CLS_VOICE)
              & (voice_line_select == `VDM_LS_SPKR);

  // Configuration registers written by good commands
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode                 <= `VDM_MODE_DATA;
      mod_sel              <= def_mod;
      automod              <= `VDM_RST_AUTOMOD;
      burst_en             <= `VDM_RST_BURST;
      min_rate             <= `VDM_R4800;
      max_rate             <= HIGH_MODEL ? `VDM_R14400 : `VDM_R9600;
      symbol_rate          <= `VDM_SYM_AUTO;
      voice_line_select    <= `VDM_LS_HANDSET;
      service_class_select <= 8'h00;
      caller_ident_enable  <= `VDM_OFF;
    end else if (do_cmd) begin
      case (cmd.opcode)
        `VDM_OP_MODE: begin
          mode        <= cmd.arg0[1:0];
          min_rate    <= cmd_min;
          max_rate    <= cmd_max;
          symbol_rate <= cmd.symbol_rate;
        end
        `VDM_OP_MODSEL: begin
          mod_sel  <= req_mod;
          automod  <= cmd.arg0[2] ? `VDM_ON : `VDM_OFF;
          min_rate <= `VDM_R4800;
          max_rate <= top_rate(req_mod);
        end
        `VDM_OP_BURST:   burst_en <= cmd.arg0[0];
        `VDM_OP_LINESEL: voice_line_select <= cmd.arg0[3:0];
        `VDM_OP_CLASS:   service_class_select <= cmd.arg0;
        `VDM_OP_CID:     caller_ident_enable <= cmd.arg0[0];
        default: ;
      endcase
    end
  end

  // Command answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rsp_ok   <= 1'b0;
      rsp_err  <= 1'b0;
      rsp_data <= 8'h00;
    end else if (ce) begin
      rsp_ok   <= cmd_valid & cmd_good;
      rsp_err  <= cmd_valid & ~cmd_good;
      if (cmd_valid & (cmd.opcode == `VDM_OP_INQUIRY))
        rsp_data <= {5'h00, HIGH_MODEL, `VDM_ON, caller_ident_enable};
    end
  end

  // Negotiation and fallback, one modulation tried per cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state      <= VDM_IDLE;
      cur_mod    <= `VDM_MOD_V61;
      disconnect <= 1'b0;
    end else if (ce) begin
      disconnect <= 1'b0;
      case (state)
        VDM_IDLE: begin
          if (link.connect_req) begin
            cur_mod <= mod_sel;
            state   <= wants_vd ? VDM_NEGOT : VDM_DATA_ONLY;
          end
        end
        VDM_NEGOT: begin
          if (link.hangup)
            state <= VDM_IDLE;
          else if (is_digital | (remote_has & fits_min))
            state <= VDM_VOICE_DATA;
          else if (!automod) begin
            disconnect <= 1'b1;
            state      <= VDM_IDLE;
          end else if (cur_mod == `VDM_MOD_V61)
            state <= VDM_DATA_ONLY;
          else
            cur_mod <= cur_mod - 2'h1;
        end
        VDM_VOICE_DATA,
        VDM_DATA_ONLY: begin
          if (link.hangup)
            state <= VDM_IDLE;
        end
        default: state <= VDM_IDLE;
      endcase
    end
  end

  // Status and path outputs, registered
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stat                <= '0;
      audio_route         <= `VDM_LS_HANDSET;
      speakerphone_active <= 1'b0;
      echo_cancel_en      <= 1'b0;
      tdm_voice_data_en   <= 1'b0;
      caller_ident_pass   <= 1'b0;
    end else if (ce) begin
      stat.voice_data_active <= (state == VDM_VOICE_DATA) & ~is_digital;
      stat.digital_active    <= (state == VDM_VOICE_DATA) & is_digital;
      stat.active_mod        <= cur_mod;
      stat.speed             <= (state == VDM_VOICE_DATA) ? vd_speed : data_rate;
      stat.audio_open        <= (state == VDM_VOICE_DATA) & chan_open;
      stat.upshifted         <= (state == VDM_VOICE_DATA) & go_up;
      audio_route            <= voice_line_select;
      speakerphone_active    <= spk_on;
      echo_cancel_en         <= spk_on;
      tdm_voice_data_en      <= (service_class_select == `VDM_CLS_TDM);
      caller_ident_pass      <= caller_ident_enable;
    end
  end

endmodule // vdm_select

/* File: verif/vdm_select_asserts.sv */
// Port checker for the voice-plus-data mode and rate selector
`timescale 1ns/100ps
`include "vdm_regs.svh"
module vdm_select_asserts #(
  parameter bit HIGH_MODEL = 1'b1
) (
  input wire logic               core_clk,
  input wire logic               nrst,
  input wire logic               ce,
  input wire logic               cmd_valid,
  input wire vdm_pkg::vdm_cmd_s  cmd,
  input wire logic               rsp_ok,
  input wire logic               rsp_err,
  input wire logic [7:0]         rsp_data,
  input wire vdm_pkg::vdm_link_s link,
  input wire vdm_pkg::vdm_stat_s stat,
  input wire logic               disconnect,
  input wire logic [3:0]         audio_route,
  input wire logic               speakerphone_active,
  input wire logic               echo_cancel_en,
  input wire logic               tdm_voice_data_en,
  input wire logic               caller_ident_pass
);
  import vdm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // A command is taken on an enabled strobe
  wire logic take = ce && cmd_valid;
  wire logic vda  = stat.voice_data_active;
  // Every command answered once, never twice
  answer_next_a: assert property (take |=> rsp_ok ^ rsp_err) else $error("command not answered");
  quiet_idle_a: assert property (!take |=> !rsp_ok && !rsp_err) else $error("answer without command");
  mode_range_a: assert property (take && cmd.opcode == `VDM_OP_MODE && cmd.arg0 > 8'h03 |=> rsp_err)
    else $error("bad mode accepted");
  mod_code_a: assert property (take && cmd.opcode == `VDM_OP_MODSEL && cmd.arg0[1:0] == 2'h3 |=> rsp_err)
    else $error("bad modulation accepted");
  sym_rsvd_a: assert property (take && cmd.opcode == `VDM_OP_MODE && cmd.symbol_rate != 3'h0 |=> rsp_err)
    else $error("reserved symbol rate accepted");
  route_copy_a: assert property (take && cmd.opcode == `VDM_OP_LINESEL && cmd.arg0 <= 8'h09
    |=> ##1 audio_route == $past(cmd.arg0[3:0], 2)) else $error("audio route not updated");
  spkr_gate_a: assert property (speakerphone_active |-> audio_route == `VDM_LS_SPKR && echo_cancel_en)
    else $error("speakerphone outside line select 6");
  disc_pulse_a: assert property (disconnect |=> !disconnect) else $error("disconnect longer than a cycle");
  v61_rate_a: assert property (vda && stat.active_mod == `VDM_MOD_V61 |-> stat.speed == `VDM_R4800)
    else $error("V.61 not at 4800");
  high_cap_a: assert property (vda && stat.active_mod == `VDM_MOD_HIGH && !stat.upshifted
    |-> stat.speed <= `VDM_R14400) else $error("high rate audio speed too high");
  // Main scenarios reached
  cover property (vda && stat.upshifted);
  cover property (disconnect);
  cover property (speakerphone_active);
endmodule // vdm_select_asserts

bind vdm_select vdm_select_asserts #(.HIGH_MODEL(HIGH_MODEL)) u_vdm_select_asserts (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_ok(rsp_ok),
  .rsp_err(rsp_err), .rsp_data(rsp_data), .link(link), .stat(stat), .disconnect(disconnect),
  .audio_route(audio_route), .speakerphone_active(speakerphone_active), .echo_cancel_en(echo_cancel_en),
  .tdm_voice_data_en(tdm_voice_data_en), .caller_ident_pass(caller_ident_pass));

/* File: verif/vdm_remote.sv */
// Remote modem model seen across the telephone line
`timescale 1ns/100ps
module vdm_remote (
  input  wire logic               dial,
  input  wire logic               drop,
  input  wire logic               vd_cfg,
  input  wire logic [2:0]         mods,
  input  wire vdm_pkg::vdm_rate_t rate,
  input  wire logic               onhook,
  input  wire logic               talk,
  output vdm_pkg::vdm_link_s      link
);
  import vdm_pkg::*;
  // Remote offers voice-data only when set up for it
  assign link.remote_voice_data = vd_cfg;
  assign link.remote_mods       = mods;
  assign link.line_rate         = rate;
  assign link.connect_req       = dial;
  assign link.hangup            = drop;
  // Local audio conditions reported through the link
  assign link.handset_onhook    = onhook;
  assign link.audio_energy      = talk;
endmodule // vdm_remote

/* File: verif/tb_top.sv */
// Self-checking bench for the voice-plus-data selector
`timescale 1ns/100ps
`include "vdm_regs.svh"
module tb_top;
  import vdm_pkg::*;
  logic       core_clk = 0, nrst = 0, ce = 1, cmd_valid = 0;
  logic       dial = 0, drop = 0, vd_cfg = 1, onhook = 0, talk = 1, hit = 0;
  logic [2:0] mods = 3'h7;
  vdm_rate_t  rate = 4'ha;
  vdm_rate_t  lr[5] = '{4'ha, 4'h9, 4'h8, 4'h7, 4'h5};
  vdm_rate_t  ls[5] = '{4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  vdm_cmd_s   cmd = '0;
  vdm_link_s  link;
  vdm_stat_s  stat;
  logic       rsp_ok, rsp_err, disc, spk, echo, tdm, cid;
  logic [7:0] rsp_data;
  logic [3:0] route;
  int         n_fail = 0, checks_done = 0;
  // Clock
  always #2.5 core_clk = ~core_clk;
  vdm_select u_vdm_select (.core_clk(core_clk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_ok(rsp_ok), .rsp_err(rsp_err), .rsp_data(rsp_data), .link(link), .stat(stat), .disconnect(disc),
    .audio_route(route), .speakerphone_active(spk), .echo_cancel_en(echo), .tdm_voice_data_en(tdm),
    .caller_ident_pass(cid));
  vdm_remote u_vdm_remote (.dial(dial), .drop(drop), .vd_cfg(vd_cfg), .mods(mods), .rate(rate),
    .onhook(onhook), .talk(talk), .link(link));
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One command, answer checked in the next cycle
  task send(input logic [2:0] op, input logic [7:0] a, input logic e, input logic hn = 0,
            input vdm_rate_t mn = 0, input logic hx = 0, input vdm_rate_t mx = 0, input logic [2:0] sy = 0);
    cmd = '{op, a, hn, mn, hx, mx, sy};
    cmd_valid = 1;
    @(negedge core_clk);
    chk({rsp_ok, rsp_err}, e ? 8'h01 : 8'h02);
  endtask
  task idle(input int n);
    cmd_valid = 0;
    repeat (n) @(negedge core_clk);
  endtask
  // Remote call set-up, disconnect pulses caught
  task call(input vdm_rate_t r, input logic [2:0] m);
    rate = r;
    mods = m;
    dial = 1;
    hit = 0;
    @(negedge core_clk);
    dial = 0;
    repeat (12) begin
      @(negedge core_clk);
      hit |= disc;
    end
  endtask
  task hang;
    drop = 1;
    @(negedge core_clk);
    drop = 0;
    idle(2);
  endtask
  task final_report;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    nrst = 1;
    chk(route, 8'h00);
    send(`VDM_OP_INQUIRY, 8'h00, 0);
    chk(rsp_data, 8'h06);
    for (int i = 0; i < 6; i++) send(`VDM_OP_MODE, i, i > 3);
    for (int i = 0; i < 4; i++) send(`VDM_OP_MODSEL, i, i == 3);
    send(`VDM_OP_MODSEL, 8'h0a, 1);
    send(`VDM_OP_MODE, 8'h02, 1, 1, 4'h3, 1, 4'h2);
    send(`VDM_OP_MODE, 8'h02, 1, 0, 4'h0, 1, 4'h5);
    send(`VDM_OP_MODE, 8'h02, 1, 0, 4'h0, 0, 4'h0, 3'h1);
    send(`VDM_OP_BURST, 8'h02, 1);
    send(`VDM_OP_LINESEL, 8'h0a, 1);
    send(3'h7, 8'h00, 1);
    send(`VDM_OP_MODE, 8'h02, 0);
    send(`VDM_OP_MODSEL, 8'h06, 0);
    idle(1);
    foreach (lr[i]) begin
      call(lr[i], 3'h7);
      chk(stat.voice_data_active, 8'h01);
      chk(stat.speed, ls[i]);
      hang;
    end
    call(4'ha, 3'h7);
    onhook = 1;
    idle(3);
    chk(stat.speed, 8'h0a);
    onhook = 0;
    hang;
    send(`VDM_OP_MODSEL, 8'h05, 0);
    idle(1);
    call(4'h4, 3'h7);
    chk(stat.speed, 8'h02);
    chk(stat.audio_open, 8'h01);
    talk = 0;
    idle(3);
    chk(stat.speed, 8'h04);
    talk = 1;
    hang;
    send(`VDM_OP_BURST, 8'h00, 0);
    idle(1);
    call(4'h4, 3'h7);
    talk = 0;
    idle(3);
    chk({stat.audio_open, stat.speed}, 8'h12);
    talk = 1;
    hang;
    send(`VDM_OP_MODSEL, 8'h06, 0);
    idle(1);
    call(4'ha, 3'h1);
    chk({stat.active_mod, stat.speed}, 8'h00);
    hang;
    vd_cfg = 0;
    call(4'ha, 3'h7);
    chk(stat.voice_data_active, 8'h00);
    vd_cfg = 1;
    hang;
    send(`VDM_OP_MODSEL, 8'h02, 0);
    idle(1);
    call(4'ha, 3'h3);
    chk(hit, 8'h01);
    hang;
    send(`VDM_OP_MODE, 8'h01, 0);
    idle(1);
    call(4'ha, 3'h7);
    chk(stat.digital_active, 8'h01);
    hang;
    send(`VDM_OP_CLASS, 8'h08, 0);
    send(`VDM_OP_LINESEL, 8'h06, 0);
    idle(1);
    chk({spk, echo, route}, 8'h36);
    send(`VDM_OP_LINESEL, 8'h05, 0);
    idle(1);
    chk({spk, route}, 8'h05);
    send(`VDM_OP_CLASS, 8'h50, 0);
    idle(1);
    chk(tdm, 8'h01);
    send(`VDM_OP_CID, 8'h01, 0);
    send(`VDM_OP_INQUIRY, 8'h00, 0);
    chk({cid, rsp_data[6:0]}, 8'h87);
    idle(2);
    final_report;
  end
endmodule // tb_top
